//--- pkg/srp_pkg.sv
// shared constants, commands and carriers for the status reporting block
package srp_pkg;

	// ****************************************
	// widths and reset values
	// ****************************************
	localparam int SRP_REG_W = 16;          // status register width
	localparam int SRP_ERR_W = 16;          // error code width, two's complement
	localparam int SRP_ERRQ_DEPTH = 8;      // default error queue depth
	localparam logic [15:0] SRP_PTR_RESET = 16'hFFFF;  // rising filter all ones
	localparam logic [15:0] SRP_NTR_RESET = 16'h0000;  // falling filter all zeros
	localparam logic [7:0] SRP_ESR_RESET = 8'h80;      // power-on event seen

	// ****************************************
	// operation register bit positions
	// ****************************************
	localparam int SRP_OP_ADJUST = 0;       // adjusting_flag
	localparam int SRP_OP_SETTLE = 1;       // settling after a setting command
	localparam int SRP_OP_MEASURE = 4;      // measuring
	localparam int SRP_OP_TRIGWAIT = 5;     // waiting for trigger
	localparam int SRP_OP_SELFTEST = 9;     // self test query running

	// ****************************************
	// status byte, event latch and poll positions
	// ****************************************
	localparam int SRP_STB_ERRQ = 2;        // error queue not empty
	localparam int SRP_STB_QUES = 3;        // questionable summary
	localparam int SRP_STB_MAV = 4;         // output buffer holds data
	localparam int SRP_STB_ESB = 5;         // event_summary_bit
	localparam int SRP_STB_MSS = 6;         // master_summary_flag
	localparam int SRP_STB_OPER = 7;        // operation summary
	localparam logic [7:0] SRP_SRQ_MASK = 8'hBC;  // bits 2,3,4,5,7 raise a request
	localparam int SRP_ESR_OPC = 0;         // operation complete
	localparam int SRP_ESR_QUERY = 2;       // query error
	localparam int SRP_ESR_DEV = 3;         // device dependent error
	localparam int SRP_ESR_EXEC = 4;        // execution error
	localparam int SRP_ESR_CMD = 5;         // command error
	localparam int SRP_PPC_SENSE = 3;       // poll config: invert choice
	localparam logic [15:0] SRP_NO_ERROR = 16'h0000;  // empty queue answer

	// ****************************************
	// commands and queries
	// ****************************************
	typedef enum logic [4:0] {
		SRP_OPER_COND_Q, SRP_OPER_EVENT_Q, SRP_OPER_ENAB_W, SRP_OPER_ENAB_Q,
		SRP_OPER_PTR_W, SRP_OPER_PTR_Q, SRP_OPER_NTR_W, SRP_OPER_NTR_Q,
		SRP_QUES_COND_Q, SRP_QUES_EVENT_Q, SRP_QUES_ENAB_W, SRP_QUES_ENAB_Q,
		SRP_STB_Q, SRP_SRE_W, SRP_SRE_Q, SRP_ESE_W, SRP_ESE_Q, SRP_ESR_Q,
		SRP_PPE_W, SRP_PPE_Q, SRP_IST_Q, SRP_PPC_W, SRP_PPU_W,
		SRP_ERR_Q, SRP_CLS_W, SRP_OPC_W
	} srp_cmd_t;

	// live activity of the instrument
	typedef struct packed {
		logic adjusting;
		logic settling;
		logic measuring;
		logic trig_wait;
		logic self_test;
	} srp_activity_t;

	// one-cycle event pulses from the command engine
	typedef struct packed {
		logic query_err;
		logic dev_err;
		logic exec_err;
		logic cmd_err;
	} srp_event_t;

	// answer to a command or query
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} srp_resp_t;

endpackage

//--- rtl/srp_err_queue.sv
// first-in first-out error queue memory with registered read data
`timescale 1ns/10ps
module srp_err_queue
	import srp_pkg::*;
#(
	parameter int DEPTH = SRP_ERRQ_DEPTH,
	parameter int WIDTH = SRP_ERR_W
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clear,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_code,
	input wire logic fetch,
	output logic [WIDTH-1:0] rd_data,
	output logic not_empty
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// refuse depths that the wrapping pointers cannot serve
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin
		$error("error queue depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];       // stored entries
	logic [AW-1:0] head_reg;             // oldest entry
	logic [AW-1:0] tail_reg;             // next free slot
	logic [AW:0] count_reg;              // entries held
	logic full;
	logic empty;
	logic do_push;
	logic do_pop;
	logic [AW-1:0] wr_slot;              // slot written this cycle
	logic [AW:0] count_next;             // fill count after this cycle

	assign full = (count_reg == (AW+1)'(DEPTH));
	assign empty = (count_reg == '0);
	// full queue drops newcomer
	// old entries survive; a clear empties first, so an error in that cycle is kept
	assign do_push = push && (clear || !full);
	assign do_pop = fetch && !empty && !clear;
	assign wr_slot = clear ? '0 : tail_reg;
	assign count_next = clear ? (AW+1)'(do_push)
		: count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);

	// entry storage, written only, never reset
	always_ff @(posedge clk)
	begin
		if (do_push)
			mem[wr_slot] <= push_code;
	end

	// fetch takes the head out; an empty queue answers zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rd_data <= '0;
		else if (fetch)
			rd_data <= empty ? WIDTH'(SRP_NO_ERROR) : mem[head_reg];
	end

	// pointers and fill count
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			head_reg <= '0;
			tail_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (clear)
				head_reg <= '0;
			else if (do_pop)
				head_reg <= head_reg + 1'b1;
			if (do_push)
				tail_reg <= wr_slot + 1'b1;
			else if (clear)
				tail_reg <= '0;
			count_reg <= count_next;
		end
	end

	// status byte queue bit, registered
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			not_empty <= 1'b0;
		else
			not_empty <= (count_next != '0);
	end

endmodule

//--- rtl/srp_status_core.sv
// status reporting: operation register, status byte, polls and error queue
// What this block does
// - operation bit 0 high during adjustment
// - bit 1 high while settling after setting
// - bit 5 high while awaiting trigger
// - bit 9 high during self test query
// - live part current; latched part cleared by read
// - questionable condition and event parts always read zero
// - request when enabled bits 2,3,4,5,7 set
// - summary bits combine masked lower sources
// - completion after complete command raises request
// - bit 7 summarises operation register
// - falling filter latches one-to-zero changes
// - serial poll returns status byte query value
// - state flag ORs the status byte bits enabled by poll mask
// - controller assigns poll line and inversion
// - dedicated query returns state flag
// - queries return the part's bit pattern
// - every err_push pulse pushes one queue entry while the queue has room or is being cleared; error events do not push
// - error query pops one; empty gives zero
// - bit 5 set by enabled event latch
// - bit 6 set while request pending
`timescale 1ns/10ps
module srp_status_core
	import srp_pkg::*;
#(
	parameter int ERRQ_DEPTH = SRP_ERRQ_DEPTH
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire srp_activity_t activity,
	input wire srp_event_t events,
	input wire logic all_done,
	input wire logic out_buf_avail,
	input wire logic err_push,
	input wire logic [SRP_ERR_W-1:0] err_code,
	input wire logic cmd_valid,
	input wire srp_cmd_t cmd_code,
	input wire logic [15:0] cmd_data,
	input wire logic spoll_req,
	input wire logic ppoll_active,
	output logic cmd_ready_reg,
	output srp_resp_t resp_reg,
	output logic srq_reg,
	output logic ist_reg,
	output logic [7:0] status_byte_reg,
	output logic spoll_valid_reg,
	output logic [7:0] spoll_byte_reg,
	output logic [7:0] ppoll_dio_reg,
	output logic [7:0] ppoll_oe_n_reg
);

	// ****************************************
	// state and storage
	// ****************************************
	typedef enum {SRP_IDLE, SRP_ERR_WAIT} srp_state_t;

	srp_state_t state_reg;               // command engine state
	logic [15:0] oper_cond_reg;          // live activity
	logic [15:0] oper_event_reg;         // latched activity
	logic [15:0] oper_enab_reg;          // summary mask
	logic [15:0] oper_ptr_reg;           // rising transition filter
	logic [15:0] oper_ntr_reg;           // falling_edge_filter
	logic [15:0] ques_enab_reg;          // stored and read back, feeds no summary
	logic [7:0] standard_event_latch;    // event latch
	logic [7:0] event_summary_mask;      // event enable
	logic [7:0] service_request_enable_mask;
	logic [7:0] poll_bit_mask;
	logic [2:0] ppc_line_reg;            // assigned data line
	logic ppc_invert_reg;                // reply inverted
	logic ppc_on_reg;                    // poll reply configured
	logic opc_armed_reg;                 // completion watch armed
	logic errq_not_empty;
	logic [SRP_ERR_W-1:0] errq_data;

	// ****************************************
	// combinational status network
	// ****************************************
	logic accept;
	logic [15:0] cond_next;
	logic [15:0] oper_set;
	logic oper_summary;
	logic event_summary_bit;
	logic master_summary_flag;
	logic [7:0] stb_next;
	logic individual_state_flag;
	logic [7:0] esr_set;
	logic [15:0] query_data;
	logic is_query;

	assign accept = cmd_valid && cmd_ready_reg;

	// live part built from activity
	always_comb
	begin
		cond_next = 16'h0000;
		cond_next[SRP_OP_ADJUST] = activity.adjusting;
		cond_next[SRP_OP_SETTLE] = activity.settling;
		cond_next[SRP_OP_MEASURE] = activity.measuring;
		cond_next[SRP_OP_TRIGWAIT] = activity.trig_wait;
		cond_next[SRP_OP_SELFTEST] = activity.self_test;
	end

	assign oper_set = (cond_next & ~oper_cond_reg & oper_ptr_reg)
		| (~cond_next & oper_cond_reg & oper_ntr_reg);

	assign oper_summary = |(oper_event_reg & oper_enab_reg);
	assign event_summary_bit = |(standard_event_latch & event_summary_mask);

	// status byte, then its master bit from the other enabled bits
	always_comb
	begin
		stb_next = 8'h00;
		stb_next[SRP_STB_ERRQ] = errq_not_empty;
		stb_next[SRP_STB_QUES] = 1'b0;
		stb_next[SRP_STB_MAV] = out_buf_avail;
		stb_next[SRP_STB_ESB] = event_summary_bit;
		stb_next[SRP_STB_OPER] = oper_summary;
		master_summary_flag = |(stb_next & service_request_enable_mask & SRP_SRQ_MASK);
		stb_next[SRP_STB_MSS] = master_summary_flag;
		individual_state_flag = |(stb_next & poll_bit_mask);
	end

	// event latch sources; completion waits for all earlier commands
	always_comb
	begin
		esr_set = 8'h00;
		esr_set[SRP_ESR_OPC] = opc_armed_reg && all_done;
		esr_set[SRP_ESR_QUERY] = events.query_err;
		esr_set[SRP_ESR_DEV] = events.dev_err;
		esr_set[SRP_ESR_EXEC] = events.exec_err;
		esr_set[SRP_ESR_CMD] = events.cmd_err;
	end

	// query answers, each the plain bit pattern of the part
	always_comb
	begin
		query_data = 16'h0000;
		is_query = 1'b1;
		unique case (cmd_code)
			SRP_OPER_COND_Q: query_data = oper_cond_reg;
			SRP_OPER_EVENT_Q: query_data = oper_event_reg;
			SRP_OPER_ENAB_Q: query_data = oper_enab_reg;
			SRP_OPER_PTR_Q: query_data = oper_ptr_reg;
			SRP_OPER_NTR_Q: query_data = oper_ntr_reg;
			SRP_QUES_COND_Q, SRP_QUES_EVENT_Q: query_data = 16'h0000;
			SRP_QUES_ENAB_Q: query_data = ques_enab_reg;
			SRP_STB_Q: query_data = {8'h00, status_byte_reg};
			SRP_SRE_Q: query_data = {8'h00, service_request_enable_mask};
			SRP_ESE_Q: query_data = {8'h00, event_summary_mask};
			SRP_ESR_Q: query_data = {8'h00, standard_event_latch};
			SRP_PPE_Q: query_data = {8'h00, poll_bit_mask};
			SRP_IST_Q: query_data = {15'h0000, ist_reg};
			default: is_query = 1'b0;
		endcase
	end

	// ****************************************
	// operation and questionable registers
	// ****************************************

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			oper_cond_reg <= 16'h0000;
		else
			oper_cond_reg <= cond_next;
	end

	// latched part clears on read, a same-cycle event still lands
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			oper_event_reg <= 16'h0000;
		else if (accept && (cmd_code == SRP_OPER_EVENT_Q || cmd_code == SRP_CLS_W))
			oper_event_reg <= oper_set;
		else
			oper_event_reg <= oper_event_reg | oper_set;
	end

	// masks and filters written by commands
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			oper_enab_reg <= 16'h0000;
			oper_ptr_reg <= SRP_PTR_RESET;
			oper_ntr_reg <= SRP_NTR_RESET;
			ques_enab_reg <= 16'h0000;
			service_request_enable_mask <= 8'h00;
			event_summary_mask <= 8'h00;
			poll_bit_mask <= 8'h00;
		end
		else if (accept)
		begin
			unique case (cmd_code)
				SRP_OPER_ENAB_W: oper_enab_reg <= cmd_data;
				SRP_OPER_PTR_W: oper_ptr_reg <= cmd_data;
				SRP_OPER_NTR_W: oper_ntr_reg <= cmd_data;
				SRP_QUES_ENAB_W: ques_enab_reg <= cmd_data;
				SRP_SRE_W: service_request_enable_mask <= cmd_data[7:0];
				SRP_ESE_W: event_summary_mask <= cmd_data[7:0];
				SRP_PPE_W: poll_bit_mask <= cmd_data[7:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// event latch and completion watch
	// ****************************************

	// read or clear empties the latch; new events win over it
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			standard_event_latch <= SRP_ESR_RESET;
		else if (accept && (cmd_code == SRP_ESR_Q || cmd_code == SRP_CLS_W))
			standard_event_latch <= esr_set;
		else
			standard_event_latch <= standard_event_latch | esr_set;
	end

	// armed by the complete command, fires once when all is done
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			opc_armed_reg <= 1'b0;
		else if (accept && cmd_code == SRP_OPC_W)
			opc_armed_reg <= 1'b1;
		else if (all_done || (accept && cmd_code == SRP_CLS_W))
			opc_armed_reg <= 1'b0;
	end

	// ****************************************
	// status byte, request and polls
	// ****************************************

	// registered summary outputs
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			status_byte_reg <= 8'h00;
			srq_reg <= 1'b0;
			ist_reg <= 1'b0;
		end
		else
		begin
			status_byte_reg <= stb_next;
			srq_reg <= master_summary_flag;
			ist_reg <= individual_state_flag;
		end
	end

	// serial poll answers with the status byte
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			spoll_valid_reg <= 1'b0;
			spoll_byte_reg <= 8'h00;
		end
		else
		begin
			spoll_valid_reg <= spoll_req;
			if (spoll_req)
				spoll_byte_reg <= status_byte_reg;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ppc_line_reg <= 3'h0;
			ppc_invert_reg <= 1'b0;
			ppc_on_reg <= 1'b0;
		end
		else if (accept && cmd_code == SRP_PPC_W)
		begin
			ppc_line_reg <= cmd_data[2:0];
			ppc_invert_reg <= cmd_data[SRP_PPC_SENSE];
			ppc_on_reg <= 1'b1;
		end
		else if (accept && cmd_code == SRP_PPU_W)
			ppc_on_reg <= 1'b0;
	end

	// one line driven with the optionally inverted flag
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ppoll_dio_reg <= 8'h00;
			ppoll_oe_n_reg <= 8'hFF;
		end
		else
		begin
			ppoll_dio_reg <= 8'h00;
			ppoll_oe_n_reg <= 8'hFF;
			if (ppoll_active && ppc_on_reg)
			begin
				ppoll_dio_reg[ppc_line_reg] <= ist_reg ^ ppc_invert_reg;
				ppoll_oe_n_reg[ppc_line_reg] <= 1'b0;
			end
		end
	end

	// ****************************************
	// command engine and error queue
	// ****************************************

	srp_err_queue #(
		.DEPTH(ERRQ_DEPTH),
		.WIDTH(SRP_ERR_W)
	) u_errq (
		.clk(clk),
		.sys_rst(sys_rst),
		.clear(accept && cmd_code == SRP_CLS_W),
		.push(err_push),
		.push_code(err_code),
		.fetch(accept && cmd_code == SRP_ERR_Q),
		.rd_data(errq_data),
		.not_empty(errq_not_empty)
	);

	// error query waits one cycle for the queue read data
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_reg <= SRP_IDLE;
			cmd_ready_reg <= 1'b0;
			resp_reg <= '0;
		end
		else
		begin
			resp_reg.valid <= 1'b0;
			cmd_ready_reg <= 1'b1;
			unique case (state_reg)
				SRP_IDLE:
				begin
					if (accept && cmd_code == SRP_ERR_Q)
					begin
						state_reg <= SRP_ERR_WAIT;
						cmd_ready_reg <= 1'b0;
					end
					else if (accept && is_query)
					begin
						resp_reg.valid <= 1'b1;
						resp_reg.data <= query_data;
					end
				end
				SRP_ERR_WAIT:
				begin
					resp_reg.valid <= 1'b1;
					resp_reg.data <= errq_data;
					state_reg <= SRP_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_adjust_live: assert property (oper_cond_reg[0] == $past(activity.adjusting))
		else $error("adjusting bit not following activity");
	a_settle_live: assert property (oper_cond_reg[1] == $past(activity.settling))
		else $error("settling bit wrong");
	a_trig_live: assert property (oper_cond_reg[5] == $past(activity.trig_wait))
		else $error("trigger wait bit wrong");
	a_selftest_live: assert property (oper_cond_reg[9] == $past(activity.self_test))
		else $error("self test bit wrong");
	a_ques_zero: assert property (resp_reg.valid
		&& $past(accept && (cmd_code == SRP_QUES_COND_Q || cmd_code == SRP_QUES_EVENT_Q))
		|-> resp_reg.data == 16'h0000)
		else $error("questionable query not zero");
	a_srq_mask: assert property (srq_reg
		== |($past(stb_next) & $past(service_request_enable_mask) & SRP_SRQ_MASK))
		else $error("request differs from masked status byte");
	a_mss_srq: assert property (status_byte_reg[6]
		== |(status_byte_reg & $past(service_request_enable_mask) & SRP_SRQ_MASK))
		else $error("master bit disagrees with enabled status bits");
	a_spoll_byte: assert property (spoll_req
		|=> spoll_valid_reg && spoll_byte_reg == $past(status_byte_reg))
		else $error("serial poll byte wrong");
	a_fall_latch: assert property (oper_cond_reg[4] && !cond_next[4]
		&& oper_ntr_reg[4] |=> oper_event_reg[4])
		else $error("falling change not latched");
	a_err_resp: assert property (accept && cmd_code == SRP_ERR_Q
		|=> !cmd_ready_reg ##1 resp_reg.valid)
		else $error("error query answer not two cycles later");
	a_event_clear: assert property (accept && cmd_code == SRP_OPER_EVENT_Q
		|=> oper_event_reg == $past(oper_set))
		else $error("latched part not cleared by read");

	c_srq_raised: cover property (!srq_reg ##1 srq_reg);
	c_opc_event: cover property (opc_armed_reg && all_done ##1 standard_event_latch[0]);
	c_ppoll_reply: cover property (ppoll_active && ppc_on_reg ##1 ppoll_oe_n_reg != 8'hFF);
	c_err_pop: cover property (errq_not_empty && accept && cmd_code == SRP_ERR_Q);

endmodule

//--- verification/srp_ctrl_model.sv
// remote controller model: launches polls and reads the data lines
`timescale 1ns/10ps
module srp_ctrl_model
(
	input wire logic clk,
	input wire logic sp_go,
	input wire logic pp_go,
	input wire logic spoll_valid_reg,
	input wire logic [7:0] spoll_byte_reg,
	input wire logic [7:0] ppoll_dio_reg,
	input wire logic [7:0] ppoll_oe_n_reg,
	output logic spoll_req = 1'b0,
	output logic ppoll_active = 1'b0,
	output logic [7:0] sp_byte = 8'h00,
	output logic [7:0] dio_wire
);
	// ****
	// poll requests
	// ****
	// poll launch
	// launched just after the edge so the core sees a settled request
	always @(posedge clk)
	begin
		spoll_req <= sp_go;
		ppoll_active <= pp_go;
	end

	always @(posedge clk)
	begin
		if (spoll_valid_reg)
			sp_byte <= spoll_byte_reg;
	end

	// pulled-up data lines
	// a released line floats high, so only a driven line shows its value
	assign dio_wire = ppoll_dio_reg | ppoll_oe_n_reg;
endmodule

//--- verification/srp_status_core_tb_top.sv
// self-checking bench for the status reporting core
`timescale 1ns/10ps
module srp_status_core_tb_top
	import srp_pkg::*;
;
	// ****
	// signals
	// ****
	logic clk, sys_rst, all_done, out_buf_avail, err_push, cmd_valid, sp_go, pp_go;
	srp_activity_t activity; // live activity levels
	srp_event_t events; // one-cycle error pulses
	logic [15:0] err_code, cmd_data;
	srp_cmd_t cmd_code;
	logic spoll_req, ppoll_active, cmd_ready_reg, srq_reg, ist_reg, spoll_valid_reg;
	srp_resp_t resp_reg;
	logic [7:0] status_byte_reg, spoll_byte_reg, ppoll_dio_reg, ppoll_oe_n_reg;
	logic [7:0] sp_byte, dio_wire;
	int n_mismatch = 0;
	int n_checks = 0;
	// activity field and its operation bit, in the same order
	logic [4:0] act_tab [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
	int bit_tab [5] = '{0, 1, 4, 5, 9};

	// small queue depth so the full case is cheap to reach
	srp_status_core #(.ERRQ_DEPTH(2)) srp_status_core_inst (.clk(clk), .sys_rst(sys_rst),
		.activity(activity), .events(events), .all_done(all_done),
		.out_buf_avail(out_buf_avail), .err_push(err_push), .err_code(err_code),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
		.spoll_req(spoll_req), .ppoll_active(ppoll_active), .cmd_ready_reg(cmd_ready_reg),
		.resp_reg(resp_reg), .srq_reg(srq_reg), .ist_reg(ist_reg),
		.status_byte_reg(status_byte_reg), .spoll_valid_reg(spoll_valid_reg),
		.spoll_byte_reg(spoll_byte_reg), .ppoll_dio_reg(ppoll_dio_reg),
		.ppoll_oe_n_reg(ppoll_oe_n_reg));

	srp_ctrl_model srp_ctrl_model_inst (.clk(clk), .sp_go(sp_go), .pp_go(pp_go),
		.spoll_valid_reg(spoll_valid_reg), .spoll_byte_reg(spoll_byte_reg),
		.ppoll_dio_reg(ppoll_dio_reg), .ppoll_oe_n_reg(ppoll_oe_n_reg),
		.spoll_req(spoll_req), .ppoll_active(ppoll_active), .sp_byte(sp_byte),
		.dio_wire(dio_wire));

	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****
	// tasks
	// ****
	// end of run verdict
	task automatic wrap_up();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// a wait that ran out counts against the run
	task automatic hang();
		n_mismatch++;
		wrap_up();
	endtask

	// compare seen against expected
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			n_mismatch++;
		end
	endtask

	// command held until an edge sees ready, dropped on the next falling edge
	task automatic wr(input srp_cmd_t c, input logic [15:0] d);
		int k = 0;
		@(negedge clk);
		cmd_code = c;
		cmd_data = d;
		cmd_valid = 1'b1;
		while (cmd_ready_reg !== 1'b1)
		begin
			k++;
			if (k > 20)
				hang();
			@(negedge clk);
		end
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask

	// query and compare the single-cycle answer
	task automatic query(input srp_cmd_t c, input logic [15:0] exp, input string nm);
		int k = 0;
		wr(c, 16'h0000);
		while (resp_reg.valid !== 1'b1)
		begin
			k++;
			if (k > 4)
				hang();
			@(negedge clk);
		end
		chk(nm, resp_reg.data, exp);
	endtask

	// wait for the request line; a low expectation first lets the chain settle
	task automatic wsrq(input logic exp, input string nm);
		int k = 0;
		if (!exp)
			repeat (4) @(negedge clk);
		while (srq_reg !== exp && k < 8)
		begin
			k++;
			@(negedge clk);
		end
		chk(nm, {15'h0000, srq_reg}, {15'h0000, exp});
	endtask

	// ****
	// scenarios
	// ****
	initial
	begin
		sys_rst = 1'b1;
		activity = '0;
		events = '0;
		all_done = 1'b0;
		out_buf_avail = 1'b0;
		err_push = 1'b0;
		err_code = 16'h0000;
		cmd_valid = 1'b0;
		cmd_code = SRP_STB_Q;
		cmd_data = 16'h0000;
		sp_go = 1'b0;
		pp_go = 1'b0;
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		// reset values come back as plain numbers
		query(SRP_ESR_Q, 16'h0080, "esr_power_on");
		query(SRP_ESR_Q, 16'h0000, "esr_read_clr");
		query(SRP_OPER_PTR_Q, 16'hFFFF, "ptr_reset");
		query(SRP_OPER_NTR_Q, 16'h0000, "ntr_reset");
		// each activity shows live, then latched until read
		for (int i = 0; i < 5; i++)
		begin
			activity = act_tab[i];
			query(SRP_OPER_COND_Q, 16'h0001 << bit_tab[i], "oper_live");
			activity = '0;
			query(SRP_OPER_COND_Q, 16'h0000, "oper_idle");
			query(SRP_OPER_EVENT_Q, 16'h0001 << bit_tab[i], "oper_latched");
			query(SRP_OPER_EVENT_Q, 16'h0000, "oper_cleared");
		end
		// questionable side stays silent whatever is enabled
		activity = 5'h1F;
		query(SRP_QUES_COND_Q, 16'h0000, "ques_live");
		query(SRP_QUES_EVENT_Q, 16'h0000, "ques_latched");
		wr(SRP_QUES_ENAB_W, 16'hFFFF);
		query(SRP_QUES_ENAB_Q, 16'hFFFF, "ques_enab");
		wr(SRP_SRE_W, 16'h0008);
		wsrq(1'b0, "srq_ques");
		activity = '0;
		wr(SRP_CLS_W, 16'h0000);
		// end of measurement through the falling filter
		wr(SRP_OPER_PTR_W, 16'h0000);
		wr(SRP_OPER_NTR_W, 16'h0010);
		wr(SRP_OPER_ENAB_W, 16'h0010);
		query(SRP_OPER_ENAB_Q, 16'h0010, "oper_enab");
		wr(SRP_SRE_W, 16'h0080);
		activity.measuring = 1'b1;
		wsrq(1'b0, "srq_rise_blocked");
		activity.measuring = 1'b0;
		wsrq(1'b1, "srq_oper_sum");
		query(SRP_STB_Q, 16'h00C0, "stb_oper");
		query(SRP_OPER_EVENT_Q, 16'h0010, "oper_fall");
		wsrq(1'b0, "srq_oper_clr");
		// completion watch raises a request via the event summary
		wr(SRP_ESE_W, 16'h0001);
		wr(SRP_SRE_W, 16'h0020);
		wr(SRP_OPC_W, 16'h0000);
		wsrq(1'b0, "srq_opc_wait");
		all_done = 1'b1;
		wsrq(1'b1, "srq_opc_done");
		query(SRP_STB_Q, 16'h0060, "stb_esb");
		query(SRP_ESR_Q, 16'h0001, "esr_opc");
		wsrq(1'b0, "srq_esb_clr");
		all_done = 1'b0;
		// every error pulse lands in its own latch bit
		wr(SRP_ESE_W, 16'h00FF);
		wr(SRP_SRE_W, 16'h00FF);
		query(SRP_SRE_Q, 16'h00FF, "sre_all");
		query(SRP_ESE_Q, 16'h00FF, "ese_all");
		for (int i = 0; i < 4; i++)
		begin
			events = srp_event_t'(4'h8 >> i);
			@(negedge clk);
			events = '0;
			wsrq(1'b1, "srq_event");
			query(SRP_ESR_Q, 16'h0004 << i, "esr_event");
			wsrq(1'b0, "srq_event_clr");
		end
		// output buffer summary against the request mask
		out_buf_avail = 1'b1;
		wr(SRP_SRE_W, 16'h0000);
		wsrq(1'b0, "srq_masked");
		query(SRP_STB_Q, 16'h0010, "stb_mav");
		wr(SRP_SRE_W, 16'h0010);
		wsrq(1'b1, "srq_mav");
		query(SRP_STB_Q, 16'h0050, "stb_mss");
		// serial poll gives the same byte as the query
		sp_go = 1'b1;
		@(negedge clk);
		sp_go = 1'b0;
		repeat (4) @(negedge clk);
		chk("spoll_byte", {8'h00, sp_byte}, 16'h0050);
		// parallel poll on line 5, plain then inverted
		wr(SRP_PPE_W, 16'h0010);
		query(SRP_PPE_Q, 16'h0010, "ppe_mirror");
		query(SRP_IST_Q, 16'h0001, "ist_query");
		for (int i = 0; i < 2; i++)
		begin
			wr(SRP_PPC_W, 16'h0005 | 16'(i << 3));
			pp_go = 1'b1;
			repeat (4) @(negedge clk);
			chk("ppoll_oe", {8'h00, ppoll_oe_n_reg}, 16'h00DF);
			chk("ppoll_line", {8'h00, dio_wire}, (i == 0) ? 16'h00FF : 16'h00DF);
			pp_go = 1'b0;
		end
		wr(SRP_PPE_W, 16'h0040);
		query(SRP_IST_Q, 16'h0001, "ist_mss");
		wr(SRP_PPE_W, 16'h0000);
		query(SRP_IST_Q, 16'h0000, "ist_off");
		wr(SRP_PPU_W, 16'h0000);
		pp_go = 1'b1;
		repeat (4) @(negedge clk);
		chk("ppoll_unconf", {8'h00, ppoll_oe_n_reg}, 16'h00FF);
		pp_go = 1'b0;
		out_buf_avail = 1'b0;
		// queue of two: third error dropped, empty answers zero
		wr(SRP_CLS_W, 16'h0000);
		wr(SRP_SRE_W, 16'h0004);
		for (int i = 1; i < 4; i++)
		begin
			err_code = {4{i[3:0]}};
			err_push = 1'b1;
			@(negedge clk);
			err_push = 1'b0;
			@(negedge clk);
		end
		wsrq(1'b1, "srq_errq");
		query(SRP_ERR_Q, 16'h1111, "err_first");
		query(SRP_ERR_Q, 16'h2222, "err_second");
		query(SRP_ERR_Q, 16'h0000, "err_empty");
		wsrq(1'b0, "srq_errq_empty");
		wrap_up();
	end
endmodule
